// ---- rtl/event_flag.sv ----
module event_flag (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Event and clear
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_out
);

    usb_det_pkg::flag_state_t st_r;
    usb_det_pkg::flag_state_t st_nxt;

    // Set beats a clear in the same cycle so no event is lost
    always_comb begin
        st_nxt = st_r;
        if (set_in) begin
            st_nxt.flag = 1'b1;
        end else if (clear_in) begin
            st_nxt.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag_out = st_r.flag;

    a_set_wins: assert property (@(posedge clk_in) disable iff (rst_in)
        set_in |=> flag_out) else $error("event flag lost on set");

endmodule

// ---- rtl/usb_charger_detect_protect.sv ----
`include "usb_det_map.svh"

module usb_charger_detect_protect (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Connector sensing
    input wire logic bus_power_valid_in,
    input wire logic overvoltage_in,
    input wire logic overcurrent_in,
    input wire logic vbus_from_accessory_in,
    input wire logic id_open_status_in,
    input wire logic [4:0] resistor_code_in,
    input wire logic audio_attach_in,
    // Charger detection front end
    input wire logic bc_done_in,
    input wire usb_det_pkg::port_type_t bc_port_type_in,
    // Supplies
    input wire logic io_supply_valid_in,
    input wire logic battery_threshold_in,
    // Switch and pin controls
    output logic host_dplus_path_out,
    output logic host_dminus_path_out,
    output logic mic_to_bus_power_output,
    output logic mic_to_dplus_out,
    output logic bus_fet_on_out,
    output logic input_disconnect_out,
    output logic charger_detect_n_out,
    output logic dplus_bias_out,
    output logic interrupt_line_n_out
);

    usb_det_pkg::core_state_t st_r;
    usb_det_pkg::core_state_t st_nxt;
    logic [`INT_COUNT-1:0] int_set;
    logic [`INT_COUNT-1:0] int_flags;
    logic int_clear;
    logic detach;
    logic attached;
    logic man_en;
    logic auto_close;
    logic charger_rec;
    logic usb_port;

    function automatic logic is_carkit(input logic [4:0] code);
        return (code == `CODE_CARKIT1) || (code == `CODE_CARKIT2);
    endfunction

    function automatic logic is_aca(input logic [4:0] code);
        return (code == `CODE_ACA_A) || (code == `CODE_ACA_B) || (code == `CODE_ACA_C);
    endfunction

    assign detach = id_open_status_in && !bus_power_valid_in;
    assign attached = st_r.det_state == usb_det_pkg::ST_ATTACHED;
    assign man_en = st_r.ctl[`CTL_MANUAL_BIT];
    assign usb_port = attached && (st_r.port != usb_det_pkg::PORT_NONE);
    assign int_clear = reg_rd_in && (reg_addr_in == `OFF_INT);

    // Open-ID ports and adapters close; car kits and dedicated chargers stay open
    assign auto_close = bus_power_valid_in && attached && !is_carkit(resistor_code_in)
        && ((resistor_code_in == `CODE_OPEN && (st_r.port == usb_det_pkg::PORT_SDP
        || st_r.port == usb_det_pkg::PORT_CDP)) || is_aca(resistor_code_in));

    // Standard port never counts as a charger
    assign charger_rec = bus_power_valid_in && (is_carkit(resistor_code_in)
        || (attached && ((resistor_code_in == `CODE_OPEN && (st_r.port == usb_det_pkg::PORT_CDP
        || st_r.port == usb_det_pkg::PORT_DCP)) || is_aca(resistor_code_in))));

    always_comb begin
        st_nxt = st_r;
        int_set = '0;
        st_nxt.vbus_d = bus_power_valid_in;
        st_nxt.code_d = resistor_code_in;

        // Detection runs once per bus power session
        case (st_r.det_state)
            usb_det_pkg::ST_IDLE: begin
                if (bus_power_valid_in) begin
                    st_nxt.det_state = usb_det_pkg::ST_DETECT;
                end
            end
            usb_det_pkg::ST_DETECT: begin
                if (!bus_power_valid_in) begin
                    st_nxt.det_state = usb_det_pkg::ST_IDLE;
                    st_nxt.port = usb_det_pkg::PORT_NONE;
                end else if (bc_done_in) begin
                    st_nxt.det_state = usb_det_pkg::ST_ATTACHED;
                    st_nxt.port = bc_port_type_in;
                end
            end
            usb_det_pkg::ST_ATTACHED: begin
                if (!bus_power_valid_in) begin
                    st_nxt.det_state = usb_det_pkg::ST_IDLE;
                    st_nxt.port = usb_det_pkg::PORT_NONE;
                end
            end
            default: begin
                st_nxt.det_state = usb_det_pkg::ST_IDLE;
                st_nxt.port = usb_det_pkg::PORT_NONE;
            end
        endcase

        // Over-voltage shutdown
        if (st_r.overvoltage_flag) begin
            if (!overvoltage_in || detach) begin
                st_nxt.overvoltage_flag = 1'b0;
            end
        end else if (overvoltage_in && !detach) begin
            st_nxt.overvoltage_flag = 1'b1;
        end

        // Current limit only applies to accessory-supplied power through a closed FET
        if (st_r.overcurrent_flag) begin
            if (!overcurrent_in || detach) begin
                st_nxt.overcurrent_flag = 1'b0;
            end
        end else if (overcurrent_in && vbus_from_accessory_in && st_r.fet && !detach) begin
            st_nxt.overcurrent_flag = 1'b1;
        end

        // Dead battery D+ bias
        if (detach || io_supply_valid_in || battery_threshold_in) begin
            st_nxt.bias = 1'b0;
        end else if (usb_port && bus_power_valid_in) begin
            st_nxt.bias = 1'b1;
        end

        // Events, each a one-cycle set into its sticky flag
        int_set[`INT_VBUS] = st_r.vbus_d != bus_power_valid_in;
        int_set[`INT_OVP] = st_nxt.overvoltage_flag != st_r.overvoltage_flag;
        int_set[`INT_OCP] = st_nxt.overcurrent_flag != st_r.overcurrent_flag;
        // Removal is always reported, key presses only with sensing on
        int_set[`INT_RES] = (st_r.code_d != resistor_code_in)
            && (!st_r.ctl[`CTL_IDDIS_BIT] || resistor_code_in == `CODE_OPEN);

        // Outputs
        if (detach) begin
            st_nxt.usb_sw = 1'b0;
            st_nxt.mic_vbus = 1'b0;
            st_nxt.mic_dp = 1'b0;
        end else if (man_en) begin
            st_nxt.usb_sw = st_r.man_sw[`MAN_USB_BIT];
            st_nxt.mic_vbus = st_r.man_sw[`MAN_MIC_VBUS_BIT];
            st_nxt.mic_dp = st_r.man_sw[`MAN_MIC_DP_BIT];
        end else begin
            st_nxt.usb_sw = auto_close;
            st_nxt.mic_vbus = 1'b0;
            st_nxt.mic_dp = 1'b0;
        end
        // FET closes once detection is done, independent of the data switch state
        st_nxt.fet = !detach && bus_power_valid_in && attached && !st_r.overvoltage_flag && !st_r.overcurrent_flag
            && (!man_en || st_r.man_sw[1:0] == `MAN_FET_CLOSED);
        st_nxt.chg_n = !charger_rec;
        st_nxt.bias_pin = st_nxt.bias || (st_r.mcc[`MCC_BIAS_BIT] && bus_power_valid_in);

        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == `OFF_CONTROL) begin
                st_nxt.ctl = reg_wdata_in;
            end else if (reg_addr_in == `OFF_INT_MASK) begin
                st_nxt.int_mask = reg_wdata_in;
            end else if (reg_addr_in == `OFF_MAN_SW) begin
                st_nxt.man_sw = reg_wdata_in;
            end else if (reg_addr_in == `OFF_MAN_CHG) begin
                st_nxt.mcc = reg_wdata_in;
            end
        end

        // Register reads, unmapped addresses return zero
        if (reg_rd_in) begin
            if (reg_addr_in == `OFF_CONTROL) begin
                st_nxt.rdata = st_r.ctl;
            end else if (reg_addr_in == `OFF_INT) begin
                st_nxt.rdata = {{(8-`INT_COUNT){1'b0}}, int_flags};
            end else if (reg_addr_in == `OFF_INT_MASK) begin
                st_nxt.rdata = st_r.int_mask;
            end else if (reg_addr_in == `OFF_RES_CODE) begin
                st_nxt.rdata = {3'h0, resistor_code_in};
            end else if (reg_addr_in == `OFF_STATUS) begin
                st_nxt.rdata = {4'h0, id_open_status_in, st_r.overcurrent_flag, st_r.overvoltage_flag, bus_power_valid_in};
            end else if (reg_addr_in == `OFF_MAN_SW) begin
                st_nxt.rdata = st_r.man_sw;
            end else if (reg_addr_in == `OFF_MAN_CHG) begin
                st_nxt.rdata = st_r.mcc;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.det_state <= usb_det_pkg::ST_IDLE;
            st_r.port <= usb_det_pkg::PORT_NONE;
            st_r.ctl <= `CTL_RESET;
            st_r.man_sw <= `MAN_SW_RESET;
            st_r.mcc <= `MCC_RESET;
            st_r.int_mask <= `INT_MASK_RESET;
            st_r.chg_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read of the interrupt register clears every flag not set in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `INT_COUNT; gi = gi + 1) begin : g_int
            event_flag u_flag (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .set_in(int_set[gi]),
                .clear_in(int_clear),
                .flag_out(int_flags[gi])
            );
        end
    endgenerate

    // Line stays quiet until software clears the global mask
    assign interrupt_line_n_out = !((|(int_flags & ~st_r.int_mask[`INT_COUNT-1:0]))
        && !st_r.ctl[`CTL_MASK_BIT]);
    assign reg_rdata_out = st_r.rdata;
    assign host_dplus_path_out = st_r.usb_sw;
    assign host_dminus_path_out = st_r.usb_sw;
    assign mic_to_bus_power_output = st_r.mic_vbus;
    assign mic_to_dplus_out = st_r.mic_dp;
    assign bus_fet_on_out = st_r.fet;
    assign input_disconnect_out = st_r.overvoltage_flag;
    assign charger_detect_n_out = st_r.chg_n;
    assign dplus_bias_out = st_r.bias_pin;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_ovp_enter;
        !st_r.overvoltage_flag && overvoltage_in && !detach;
    endsequence

    sequence s_ovp_exit;
        st_r.overvoltage_flag && (!overvoltage_in || detach);
    endsequence

    sequence s_ocp_enter;
        !st_r.overcurrent_flag && overcurrent_in && vbus_from_accessory_in && st_r.fet && !detach;
    endsequence

    sequence s_code_read;
        reg_rd_in && reg_addr_in == `OFF_RES_CODE;
    endsequence

    a_detach_opens: assert property (detach |=> !host_dplus_path_out && !bus_fet_on_out
        && !mic_to_bus_power_output) else $error("switches not opened on detach");
    a_manual_fet: assert property (man_en && st_r.man_sw[1:0] != `MAN_FET_CLOSED
        |=> !bus_fet_on_out) else $error("FET closed against manual setting");
    a_ovp_enter: assert property (s_ovp_enter |=> input_disconnect_out && int_flags[`INT_OVP])
        else $error("over-voltage entry not reported");
    a_ovp_exit: assert property (s_ovp_exit |=> !input_disconnect_out && int_flags[`INT_OVP])
        else $error("over-voltage exit not reported");
    a_ocp_fet_open: assert property (st_r.overcurrent_flag |=> !bus_fet_on_out)
        else $error("FET left closed in over-current");
    a_ocp_exit: assert property (st_r.overcurrent_flag && !overcurrent_in |=> !st_r.overcurrent_flag ##0 int_flags[`INT_OCP])
        else $error("over-current exit not flagged");
    a_chg_needs_vbus: assert property (!bus_power_valid_in |=> charger_detect_n_out
        && !host_dplus_path_out || man_en) else $error("charger detect or auto-close without bus power");
    a_classify_vbus: assert property (!bus_power_valid_in |=> st_r.det_state == usb_det_pkg::ST_IDLE)
        else $error("classification kept without bus power");
    a_bias_release: assert property (io_supply_valid_in && !st_r.mcc[`MCC_BIAS_BIT]
        |=> !dplus_bias_out) else $error("D+ bias kept with I/O supply valid");
    a_res_change: assert property (resistor_code_in != st_r.code_d && !st_r.ctl[`CTL_IDDIS_BIT]
        |=> int_flags[`INT_RES]) else $error("resistor change not flagged");
    a_irq_masked: assert property (st_r.ctl[`CTL_MASK_BIT] |-> interrupt_line_n_out)
        else $error("interrupt line active while masked");
    a_ocp_enter: assert property (s_ocp_enter |=> st_r.overcurrent_flag && int_flags[`INT_OCP])
        else $error("over-current entry not reported");
    a_fet_after_detect: assert property (!attached |=> !bus_fet_on_out)
        else $error("FET closed before detection done");
    a_fet_auto_on: assert property (bus_power_valid_in && attached && !man_en && !st_r.overvoltage_flag && !st_r.overcurrent_flag
        |=> bus_fet_on_out) else $error("FET not closed on valid bus power");
    a_sdp_closes: assert property (bus_power_valid_in && attached && !man_en
        && resistor_code_in == `CODE_OPEN && st_r.port == usb_det_pkg::PORT_SDP
        |=> host_dplus_path_out && host_dminus_path_out && charger_detect_n_out)
        else $error("standard port not auto-closed");
    a_dcp_open: assert property (bus_power_valid_in && attached && !man_en
        && resistor_code_in == `CODE_OPEN && st_r.port == usb_det_pkg::PORT_DCP
        |=> !host_dplus_path_out && !charger_detect_n_out) else $error("dedicated charger wrong");
    a_carkit_open: assert property (bus_power_valid_in && is_carkit(resistor_code_in) && !man_en
        |=> !host_dplus_path_out && !charger_detect_n_out) else $error("car kit outputs wrong");
    a_aca_closes: assert property (bus_power_valid_in && attached && !man_en && is_aca(resistor_code_in)
        |=> host_dplus_path_out && !charger_detect_n_out) else $error("adapter not auto-closed");
    a_manual_usb: assert property (man_en && !detach && st_r.man_sw[`MAN_USB_BIT] |=> host_dplus_path_out)
        else $error("manual data path not applied");
    a_bias_dead: assert property (usb_port && bus_power_valid_in
        && !io_supply_valid_in && !battery_threshold_in |=> dplus_bias_out) else $error("D+ bias missing");
    a_bias_battery: assert property (battery_threshold_in && !st_r.mcc[`MCC_BIAS_BIT] |=> !dplus_bias_out)
        else $error("D+ bias kept with battery good");
    a_bias_force: assert property (st_r.mcc[`MCC_BIAS_BIT] && bus_power_valid_in |=> dplus_bias_out)
        else $error("forced D+ bias not applied");
    a_code_report: assert property (s_code_read |=> reg_rdata_out == {3'h0, $past(resistor_code_in)})
        else $error("resistor code not reported");

endmodule

// ---- rtl/usb_det_map.svh ----
// Function
// - Port and charger classification happens only while bus power is present.
// - Standard, charging and adapter ports auto-join host data paths and pass bus power.
// - Manual switch enable takes data switch states from the manual switch register.
// - Valid bus power closes the FET once detection completes, unless manual mode with FET field not 11.
// - Any recognised charger except a standard port drives charger detect low.
// - Car kit codes 00111 and 00011 keep switches open and assert charger detect.
// - Open ID: dedicated charger open and asserted, charging port closed, standard port closed.
// - Resistor code is reported regardless of switch state or bus power.
// - Auto-close and charger detect happen only while bus power is valid.
// - FET turns on when charger detection completes, independent of the data switches.
// - USB port detected with battery and I/O supply invalid applies D+ bias.
// - D+ bias is withdrawn on detach, I/O supply valid or battery above threshold.
// - Manual charge control bit 2 forces D+ bias, only while bus power valid.
// - Over-voltage disconnects input, sets interrupt bit and over-voltage status.
// - Over-voltage exit on voltage drop or detach raises interrupt, clears status.
// - Over-current with accessory-supplied power opens FET, sets interrupt and status.
// - Over-current exit on current drop or detach sets the interrupt bit again.
// - ID resistance change with ID sensing enabled raises an interrupt.
// - Powered audio accessory interrupts on bus power valid; host then sets switches.
// - Detach opens all switches and the FET, even in manual mode.
`ifndef USB_DET_MAP_SVH
`define USB_DET_MAP_SVH

`define OFF_CONTROL 8'h02
`define OFF_INT 8'h03
`define OFF_INT_MASK 8'h05
`define OFF_RES_CODE 8'h0a
`define OFF_STATUS 8'h0b
`define OFF_MAN_SW 8'h13
`define OFF_MAN_CHG 8'h14

`define CTL_MASK_BIT 0
`define CTL_MANUAL_BIT 1
`define CTL_IDDIS_BIT 2
`define CTL_RESET 8'h01

`define MAN_SW_RESET 8'h00
`define MAN_FET_CLOSED 2'h3
`define MAN_USB_BIT 2
`define MAN_MIC_VBUS_BIT 3
`define MAN_MIC_DP_BIT 4

`define MCC_RESET 8'h00
`define MCC_BIAS_BIT 2
`define INT_MASK_RESET 8'h00

`define INT_COUNT 4
`define INT_VBUS 0
`define INT_OVP 1
`define INT_OCP 2
`define INT_RES 3

`define STAT_VBUS 0
`define STAT_OVP 1
`define STAT_OCP 2
`define STAT_IDOPEN 3

`define CODE_OPEN 5'h00
`define CODE_CARKIT1 5'h07
`define CODE_CARKIT2 5'h03
`define CODE_ACA_A 5'h0a
`define CODE_ACA_B 5'h0d
`define CODE_ACA_C 5'h11

`endif

// ---- rtl/usb_det_pkg.sv ----
package usb_det_pkg;

    typedef enum logic [1:0] {PORT_NONE, PORT_SDP, PORT_CDP, PORT_DCP} port_type_t;

    typedef enum logic [1:0] {ST_IDLE, ST_DETECT, ST_ATTACHED} det_state_t;

    typedef struct packed {
        logic flag;
    } flag_state_t;

    typedef struct packed {
        det_state_t det_state;
        port_type_t port;
        logic [7:0] ctl;
        logic [7:0] man_sw;
        logic [7:0] mcc;
        logic [7:0] int_mask;
        logic overvoltage_flag;
        logic overcurrent_flag;
        logic bias;
        logic vbus_d;
        logic [4:0] code_d;
        logic usb_sw;
        logic mic_vbus;
        logic mic_dp;
        logic fet;
        logic chg_n;
        logic bias_pin;
        logic [7:0] rdata;
    } core_state_t;

endpackage

// ---- tb/usb_charger_detect_protect_test.sv ----
module usb_charger_detect_protect_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic io_ok = 1'b1;
    logic bat_ok = 1'b1;
    logic [2:0] plug = 3'h0;
    logic slow = 1'b0;
    logic ov = 1'b0;
    logic oc = 1'b0;
    logic pv, povr, pocr, pacc, pidopen, paud, pdone;
    logic [4:0] pcode;
    usb_det_pkg::port_type_t ptype;
    logic dp, dm, micv, micd, fet, disc, chg_n, bias, int_n;
    int err_total = 0;
    int checks = 0;
    logic [7:0] d;

    usb_far_end far (.clk_in(clk_in), .plug_in(plug), .slow_in(slow), .ov_in(ov), .oc_in(oc),
        .bus_power_valid_out(pv), .overvoltage_out(povr), .overcurrent_out(pocr),
        .vbus_from_accessory_out(pacc), .id_open_status_out(pidopen), .resistor_code_out(pcode),
        .audio_attach_out(paud), .bc_done_out(pdone), .bc_port_type_out(ptype));

    usb_charger_detect_protect dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .bus_power_valid_in(pv), .overvoltage_in(povr), .overcurrent_in(pocr),
        .vbus_from_accessory_in(pacc), .id_open_status_in(pidopen), .resistor_code_in(pcode),
        .audio_attach_in(paud), .bc_done_in(pdone), .bc_port_type_in(ptype),
        .io_supply_valid_in(io_ok), .battery_threshold_in(bat_ok), .host_dplus_path_out(dp),
        .host_dminus_path_out(dm), .mic_to_bus_power_output(micv), .mic_to_dplus_out(micd),
        .bus_fet_on_out(fet), .input_disconnect_out(disc), .charger_detect_n_out(chg_n),
        .dplus_bias_out(bias), .interrupt_line_n_out(int_n));

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    task automatic print_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    // Outputs packed as {mic_v, mic_d, d+, d-, fet, chg_n, bias, disconnect}
    task automatic see(input string name, input logic [7:0] exp, input logic [7:0] mask);
        check(name, exp & mask, {micv, micd, dp, dm, fet, chg_n, bias, disc} & mask);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_in);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        v = rdata;
    endtask

    task automatic plug_to(input logic [2:0] k, input int n);
        @(negedge clk_in);
        plug <= k;
        cyc(n);
    endtask

    task automatic t_reset();
        logic [7:0] a [5] = '{8'h02, 8'h13, 8'h14, 8'h05, 8'h7e};
        logic [7:0] e [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            reg_rd(a[i], d);
            check("reset register", e[i], d);
        end
        see("idle outputs", 8'h04, 8'hff);
        check("idle interrupt line", 8'h01, {7'h00, int_n});
    endtask

    task automatic t_ports();
        logic [7:0] e [7] = '{8'h04, 8'h3c, 8'h38, 8'h08, 8'h08, 8'h08, 8'h38};
        logic [4:0] c [7] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h07, 5'h03, 5'h0a};
        slow <= 1'b1;
        plug_to(3'h1, 8);
        see("before detection done", 8'h04, 8'hfc);
        cyc(40);
        see("after slow detection", 8'h3c, 8'hfc);
        slow <= 1'b0;
        for (int k = 1; k < 7; k++) begin
            plug_to(3'h0, 4);
            see("detached", 8'h04, 8'hff);
            plug_to(k[2:0], 12);
            see("port kind outputs", e[k], 8'hfc);
            reg_rd(8'h0a, d);
            check("resistor code", {3'h0, c[k]}, d);
        end
        plug_to(3'h7, 8);
        reg_rd(8'h0a, d);
        check("code without bus power", 8'h0f, d);
        see("unpowered audio", 8'h04, 8'hfc);
        plug_to(3'h0, 6);
    endtask

    task automatic t_irq();
        reg_rd(8'h03, d);
        plug_to(3'h1, 12);
        check("masked line", 8'h01, {7'h00, int_n});
        reg_rd(8'h03, d);
        check("bus power change flag", 8'h01, d & 8'h01);
        plug_to(3'h0, 6);
        reg_rd(8'h03, d);
        reg_wr(8'h02, 8'h00);
        plug_to(3'h7, 8);
        check("resistor change line", 8'h00, {7'h00, int_n});
        reg_rd(8'h03, d);
        check("resistor change flag", 8'h08, d & 8'h08);
        cyc(2);
        check("line after clear", 8'h01, {7'h00, int_n});
        plug_to(3'h0, 6);
        reg_rd(8'h03, d);
        reg_wr(8'h02, 8'h04);
        plug_to(3'h7, 8);
        reg_rd(8'h03, d);
        check("key flag sensing off", 8'h00, d & 8'h08);
        plug_to(3'h0, 6);
        reg_rd(8'h03, d);
        check("removal flag sensing off", 8'h08, d & 8'h08);
        reg_wr(8'h02, 8'h00);
    endtask

    task automatic t_protect();
        plug_to(3'h1, 70);
        reg_rd(8'h03, d);
        ov <= 1'b1;
        cyc(4);
        see("overvoltage shutdown", 8'h01, 8'h09);
        reg_rd(8'h0b, d);
        check("overvoltage status set", 8'h02, d & 8'h02);
        reg_rd(8'h03, d);
        check("overvoltage flag enter", 8'h02, d & 8'h02);
        ov <= 1'b0;
        cyc(4);
        see("overvoltage exit", 8'h00, 8'h01);
        reg_rd(8'h0b, d);
        check("overvoltage status clear", 8'h00, d & 8'h02);
        reg_rd(8'h03, d);
        check("overvoltage flag exit", 8'h02, d & 8'h02);
        oc <= 1'b1;
        cyc(4);
        see("overcurrent opens fet", 8'h00, 8'h08);
        reg_rd(8'h0b, d);
        check("overcurrent status set", 8'h04, d & 8'h04);
        reg_rd(8'h03, d);
        check("overcurrent flag enter", 8'h04, d & 8'h04);
        oc <= 1'b0;
        cyc(4);
        reg_rd(8'h0b, d);
        check("overcurrent status clear", 8'h00, d & 8'h04);
        reg_rd(8'h03, d);
        check("overcurrent flag exit", 8'h04, d & 8'h04);
        plug_to(3'h0, 6);
    endtask

    task automatic t_manual();
        reg_wr(8'h02, 8'h02);
        reg_wr(8'h13, 8'h07);
        plug_to(3'h2, 12);
        see("manual usb and fet", 8'h38, 8'hf8);
        reg_wr(8'h13, 8'h04);
        cyc(3);
        see("manual fet field open", 8'h30, 8'hf8);
        reg_wr(8'h13, 8'h18);
        cyc(3);
        see("manual mic routing", 8'hc0, 8'hf8);
        plug_to(3'h0, 6);
        see("detach in manual", 8'h04, 8'hfc);
        reg_wr(8'h13, 8'h00);
        reg_wr(8'h02, 8'h00);
    endtask

    task automatic t_bias();
        io_ok = 1'b0;
        bat_ok = 1'b0;
        plug_to(3'h3, 12);
        see("dead battery bias", 8'h02, 8'h02);
        io_ok = 1'b1;
        cyc(4);
        see("bias off io valid", 8'h00, 8'h02);
        io_ok = 1'b0;
        cyc(4);
        see("bias back on", 8'h02, 8'h02);
        bat_ok = 1'b1;
        cyc(4);
        see("bias off battery good", 8'h00, 8'h02);
        io_ok = 1'b1;
        reg_wr(8'h14, 8'h04);
        cyc(3);
        see("forced bias", 8'h02, 8'h02);
        plug_to(3'h0, 6);
        see("forced bias needs bus power", 8'h00, 8'h02);
        reg_wr(8'h14, 8'h00);
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        t_irq();
        t_ports();
        t_protect();
        t_manual();
        t_bias();
        print_verdict();
    end
endmodule

// ---- tb/usb_far_end.sv ----
module usb_far_end (
    // Clock and scenario control
    input wire logic clk_in,
    input wire logic [2:0] plug_in,
    input wire logic slow_in,
    input wire logic ov_in,
    input wire logic oc_in,
    // Connector side as seen by the block
    output logic bus_power_valid_out,
    output logic overvoltage_out,
    output logic overcurrent_out,
    output logic vbus_from_accessory_out,
    output logic id_open_status_out,
    output logic [4:0] resistor_code_out,
    output logic audio_attach_out,
    output logic bc_done_out,
    output usb_det_pkg::port_type_t bc_port_type_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Kinds: 1 standard, 2 charging, 3 dedicated, 4/5 car kits, 6 adapter, 7 unpowered audio
    logic [5:0] age_r = 6'h00;
    logic [4:0] codes [8] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h07, 5'h03, 5'h0a, 5'h0f};
    initial begin
        bus_power_valid_out = 1'b0;
        overvoltage_out = 1'b0;
        overcurrent_out = 1'b0;
        vbus_from_accessory_out = 1'b0;
        id_open_status_out = 1'b1;
        resistor_code_out = 5'h00;
        audio_attach_out = 1'b0;
        bc_done_out = 1'b0;
        bc_port_type_out = usb_det_pkg::PORT_NONE;
    end
    always @(negedge clk_in) begin
        age_r <= (plug_in == 3'h0) ? 6'h00 : (age_r == 6'h3f) ? age_r : age_r + 6'h01;
        bus_power_valid_out <= (plug_in != 3'h0) && (plug_in != 3'h7);
        vbus_from_accessory_out <= (plug_in != 3'h0) && (plug_in != 3'h7);
        id_open_status_out <= (plug_in < 3'h4);
        resistor_code_out <= codes[plug_in];
        audio_attach_out <= (plug_in == 3'h7);
        // Slow front end finishes detection late, prompt one after two cycles
        bc_done_out <= (plug_in != 3'h0) && (age_r >= (slow_in ? 6'h20 : 6'h02));
        bc_port_type_out <= (plug_in < 3'h4) ? usb_det_pkg::port_type_t'(plug_in[1:0]) : usb_det_pkg::PORT_NONE;
        overvoltage_out <= ov_in && (plug_in != 3'h0);
        // Heavy draw only once the output has long been valid
        overcurrent_out <= oc_in && (age_r == 6'h3f);
    end
endmodule
